// ==== core_exec.sv ====
// Execution logic for a subset of the 8-bit core's instructions
//
// Overview of operation
// RL1: Enable-interrupts sets global enable, one cycle
// RL2: Increment register; dest 0 working, 1 register
// RL3: Increment-skip writes result per destination select
// RL4: Zero result discards fetched next instruction
// RL5: Increment-skip: one cycle, two when skipping
// RL6: Jump target is table pointer and working
// RL7: Computed jump takes two cycles, flags kept
// RL8: Trap pushes program counter plus one
// RL9: Trap then loads vector 0x001 into PC
// RL10: OR immediate into working, updates flag, one cycle
// RL11: Null flag set on zero result, else cleared
//
// An instruction is accepted on the rising mclk edge where instr_valid and
// instr_ready are both high. Its effects appear on the registered outputs
// from that edge on. Multi-cycle operations drop instr_ready for the extra
// cycles, so the decoder naturally sees the required cycle counts.
//
// Timing hazards and limitations:
// - reg_rdata feeds the arithmetic unit combinationally, so the register
//   file must present the addressed value in the same cycle as the request.
// - The skip decision also depends on reg_rdata through the zero detect, so
//   instr_ready after a skip follows the operand, not only the op code.
// - The computed jump uses the working register value from before the edge;
//   a working register update and a jump cannot be issued in one cycle.
// - pc_current must hold the address of the instruction being issued; the
//   trap return address wraps within the 11-bit program counter.
// - Op codes 0 and 7 are accepted and change nothing, so a stalled decoder
//   can present them freely.
// - The increment-and-skip leaves result_null_flag alone; only the plain
//   increment and the OR immediate update it.
// - Strobes (reg_we, pc_load, stack_push, discard_next) stand for one cycle;
//   the address and data outputs beside them hold until the next strobe.
// - The trap is treated as a two-cycle operation, like the computed jump.
//
// Interrupt enable has no clear path in this subset; it only leaves its
// reset value through the enable-interrupts operation.
`timescale 1ns/1ns
`include "core_exec_params.svh"
module core_exec
	import core_exec_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire logic                    instr_valid,
	input  wire logic [2:0]              instr_op,
	input  wire logic [`RADDR_W-1:0]     instr_reg_addr,
	input  wire logic                    instr_dest,
	input  wire logic [`DATA_W-1:0]      instr_imm,
	input  wire logic [`DATA_W-1:0]      reg_rdata,
	input  wire logic [`PC_HI_W-1:0]     table_high_pointer,
	input  wire logic [`PC_W-1:0]        pc_current,
	output logic                         instr_ready,
	output logic [`DATA_W-1:0]           working_register,
	output logic                         global_interrupt_enable,
	output logic                         result_null_flag,
	output logic                         reg_we,
	output logic [`RADDR_W-1:0]          reg_waddr,
	output logic [`DATA_W-1:0]           reg_wdata,
	output logic                         pc_load,
	output logic [`PC_W-1:0]             pc_value,
	output logic                         stack_push,
	output logic [`PC_W-1:0]             stack_data,
	output logic                         discard_next
);

	// Internal carrier to the arithmetic unit and the sequencer
	exec_if ex ();

	exec_op_t                op;            // Decoded operation
	logic                    accept;        // Instruction taken this cycle

	// Architectural state
	logic [`DATA_W-1:0]      wreg_r;        // Working register
	logic [`DATA_W-1:0]      wreg_nxt;      // Next working register
	logic                    ien_r;         // Global interrupt enable
	logic                    ien_nxt;       // Next global interrupt enable
	logic                    null_r;        // Zero result flag
	logic                    null_nxt;      // Next zero result flag

	// Register file write port
	logic                    reg_we_r;      // Write strobe
	logic                    reg_we_nxt;    // Next write strobe
	logic [`RADDR_W-1:0]     reg_waddr_r;   // Write address
	logic [`RADDR_W-1:0]     reg_waddr_nxt; // Next write address
	logic [`DATA_W-1:0]      reg_wdata_r;   // Write data
	logic [`DATA_W-1:0]      reg_wdata_nxt; // Next write data

	// Program flow outputs
	logic                    pc_load_r;     // Program counter load strobe
	logic                    pc_load_nxt;   // Next load strobe
	logic [`PC_W-1:0]        pc_value_r;    // Program counter load value
	logic [`PC_W-1:0]        pc_value_nxt;  // Next load value
	logic                    push_r;        // Stack push strobe
	logic                    push_nxt;      // Next push strobe
	logic [`PC_W-1:0]        push_data_r;   // Return address pushed
	logic [`PC_W-1:0]        push_data_nxt; // Next return address
	logic                    discard_r;     // Discard fetched instruction
	logic                    discard_nxt;   // Next discard strobe

	// Build the computed jump target from pointer and working register
	function automatic logic [`PC_W-1:0] jump_target(
		input logic [`PC_HI_W-1:0] hi,
		input logic [`DATA_W-1:0]  lo
	);
		jump_target = {hi[`TPTR_MSB:`TPTR_LSB], lo}; // RL6
	endfunction

	// Return address: current program counter plus one
	function automatic logic [`PC_W-1:0] return_addr(input logic [`PC_W-1:0] pc);
		return_addr = pc + 11'h001;
	endfunction

	// Decode and accept
	assign op     = exec_op_t'(instr_op);
	assign accept = instr_valid && ex.ready;

	// Drive the arithmetic unit and sequencer
	assign ex.op      = op;
	assign ex.operand = reg_rdata;
	assign ex.wreg    = wreg_r;
	assign ex.imm     = instr_imm;
	assign ex.start   = accept;

	// Extra cycles per operation; skip only when the increment wraps to zero
	always_comb begin
		unique case (op)
			OP_PLUS_ONE_SKIP: begin
				ex.extra = ex.result_zero ? `EXTRA_SKIP : `EXTRA_NONE; // RL5
			end
			OP_COMPUTED_JUMP: begin
				// Branch always needs a second cycle
				ex.extra = `EXTRA_JUMP; // RL7
			end
			OP_SOFT_TRAP: begin
				// Push and vector take a second cycle
				ex.extra = `EXTRA_TRAP;
			end
			default: begin
				// Single-cycle operations
				ex.extra = `EXTRA_NONE;
			end
		endcase
	end

	// Arithmetic unit
	exec_alu u_alu (
		.bus   (ex.alu)
	);

	// Cycle sequencer
	exec_seq u_seq (
		.mclk  (mclk),
		.rst_n (rst_n),
		.bus   (ex.seq)
	);

	// Next values of architectural state
	always_comb begin
		wreg_nxt = wreg_r;
		ien_nxt  = ien_r;
		null_nxt = null_r;
		if (accept) begin
			unique case (op)
				OP_ENABLE_INT: begin
					// Allow all interrupt requests
					ien_nxt = 1'b1; // RL1
				end
				OP_PLUS_ONE: begin
					// Result to working register when destination is 0
					if (!instr_dest) begin
						wreg_nxt = ex.result; // RL2
					end
					null_nxt = ex.result_zero; // RL11
				end
				OP_PLUS_ONE_SKIP: begin
					// Flags untouched, only the destination changes
					if (!instr_dest) begin
						wreg_nxt = ex.result; // RL3
					end
				end
				OP_OR_IMM: begin
					// Working register always takes the OR result
					wreg_nxt = ex.result; // RL10
					null_nxt = ex.result_zero; // RL11
				end
				default: begin
					// Jump and trap leave state and flags alone
					wreg_nxt = wreg_r; // RL7
				end
			endcase
		end
	end

	// Architectural state registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			// Reset to idle values
			wreg_r <= `WREG_RST;
			ien_r  <= `IEN_RST;
			null_r <= `NULL_FLAG_RST;
		end else begin
			// Take the computed next values
			wreg_r <= wreg_nxt;
			ien_r  <= ien_nxt;
			null_r <= null_nxt;
		end
	end

	// Next values of the register file write port
	always_comb begin
		reg_we_nxt    = 1'b0;
		reg_waddr_nxt = reg_waddr_r;
		reg_wdata_nxt = reg_wdata_r;
		// Destination 1 writes the result back to the source register
		if (accept && instr_dest && (op == OP_PLUS_ONE || op == OP_PLUS_ONE_SKIP)) begin
			reg_we_nxt    = 1'b1; // RL2 RL3
			reg_waddr_nxt = instr_reg_addr;
			reg_wdata_nxt = ex.result;
		end
	end

	// Register file write port registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			// No write pending after reset
			reg_we_r    <= 1'b0;
			reg_waddr_r <= `RADDR_RST;
			reg_wdata_r <= `WREG_RST;
		end else begin
			reg_we_r    <= reg_we_nxt;
			reg_waddr_r <= reg_waddr_nxt;
			reg_wdata_r <= reg_wdata_nxt;
		end
	end

	// Next values of the program flow outputs
	always_comb begin
		pc_load_nxt   = 1'b0;
		pc_value_nxt  = pc_value_r;
		push_nxt      = 1'b0;
		push_data_nxt = push_data_r;
		discard_nxt   = 1'b0;
		if (accept) begin
			unique case (op)
				OP_PLUS_ONE_SKIP: begin
					// Zero result turns the prefetched instruction into a no-op
					discard_nxt = ex.result_zero; // RL4
				end
				OP_COMPUTED_JUMP: begin
					// Unconditional branch to the computed target
					pc_load_nxt  = 1'b1; // RL6
					pc_value_nxt = jump_target(table_high_pointer, wreg_r); // RL6
				end
				OP_SOFT_TRAP: begin
					// Push return address and vector to the trap entry in the same cycle
					push_nxt      = 1'b1; // RL8
					push_data_nxt = return_addr(pc_current); // RL8
					pc_load_nxt   = 1'b1; // RL9
					pc_value_nxt  = `TRAP_VECTOR; // RL9
				end
				default: begin
					// No change of program flow
					pc_load_nxt = 1'b0;
				end
			endcase
		end
	end

	// Program flow registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			// No flow change pending after reset
			pc_load_r   <= 1'b0;
			pc_value_r  <= `PC_RST;
			push_r      <= 1'b0;
			push_data_r <= `PC_RST;
			discard_r   <= 1'b0;
		end else begin
			pc_load_r   <= pc_load_nxt;
			pc_value_r  <= pc_value_nxt;
			push_r      <= push_nxt;
			push_data_r <= push_data_nxt;
			discard_r   <= discard_nxt;
		end
	end

	// Outputs come straight from flops
	assign instr_ready             = ex.ready;
	assign working_register        = wreg_r;
	assign global_interrupt_enable = ien_r;
	assign result_null_flag        = null_r;
	assign reg_we                  = reg_we_r;
	assign reg_waddr               = reg_waddr_r;
	assign reg_wdata               = reg_wdata_r;
	assign pc_load                 = pc_load_r;
	assign pc_value                = pc_value_r;
	assign stack_push              = push_r;
	assign stack_data              = push_data_r;
	assign discard_next            = discard_r;

endmodule

// ==== core_exec_params.svh ====
// Constants for the instruction execution subset: widths, vectors, reset values, cycle counts
`ifndef CORE_EXEC_PARAMS_SVH
`define CORE_EXEC_PARAMS_SVH

// Datapath widths
`define DATA_W              8
`define RADDR_W             7
`define PC_W                11
`define PC_HI_W             3

// Field positions inside the program counter and table pointer
`define PC_HI_MSB           10
`define PC_HI_LSB           8
`define PC_LO_MSB           7
`define PC_LO_LSB           0
`define TPTR_MSB            2
`define TPTR_LSB            0

// Fixed software trap vector
`define TRAP_VECTOR         11'h001

// Reset values
`define WREG_RST            8'h00
`define IEN_RST             1'b0
`define NULL_FLAG_RST       1'b0
`define PC_RST              11'h000
`define RADDR_RST           7'h00

// Extra cycles after the issue cycle, per operation class
`define EXTRA_NONE          2'h0
`define EXTRA_SKIP          2'h1
`define EXTRA_JUMP          2'h1
`define EXTRA_TRAP          2'h1

`endif

// ==== core_exec_pkg.sv ====
// Types shared by the execution subset modules
package core_exec_pkg;

	// Operation selector presented by the decoder
	typedef enum logic [2:0] {
		OP_NONE          = 3'h0,
		OP_ENABLE_INT    = 3'h1,
		OP_PLUS_ONE      = 3'h2,
		OP_PLUS_ONE_SKIP = 3'h3,
		OP_COMPUTED_JUMP = 3'h4,
		OP_SOFT_TRAP     = 3'h5,
		OP_OR_IMM        = 3'h6
	} exec_op_t;

	// Sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_HOLD = 2'b10
	} seq_state_t;

endpackage

// ==== exec_if.sv ====
// Carrier between the execution core, its arithmetic unit and its cycle sequencer
`timescale 1ns/1ns
interface exec_if;
	import core_exec_pkg::*;

	exec_op_t     op;          // Operation under execution
	logic [7:0]   operand;     // Register operand value
	logic [7:0]   wreg;        // Working register value
	logic [7:0]   imm;         // Immediate field
	logic [7:0]   result;      // Arithmetic result
	logic         result_zero; // Result is all zeros
	logic         start;       // Instruction accepted this cycle
	logic [1:0]   extra;       // Extra cycles to hold after issue
	logic         ready;       // Sequencer can accept an instruction

	modport core (output op, operand, wreg, imm, start, extra, input result, result_zero, ready);
	modport alu  (input op, operand, wreg, imm, output result, result_zero);
	modport seq  (input start, extra, output ready);
endinterface

// ==== exec_alu.sv ====
// Arithmetic unit: increment and OR-immediate with zero detection
`timescale 1ns/1ns
`include "core_exec_params.svh"
module exec_alu
	import core_exec_pkg::*;
(
	exec_if.alu    bus
);

	// Add one, wrapping from all ones to zero
	function automatic logic [7:0] plus_one(input logic [7:0] v);
		plus_one = v + 8'h01;
	endfunction

	// Zero detect on an 8-bit result
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction

	// Select result by operation
	always_comb begin
		unique case (bus.op)
			OP_PLUS_ONE,
			OP_PLUS_ONE_SKIP: begin
				bus.result = plus_one(bus.operand); // RL2
			end
			OP_OR_IMM: begin
				bus.result = bus.wreg | bus.imm; // RL10
			end
			default: begin
				bus.result = bus.wreg;
			end
		endcase
		bus.result_zero = is_zero(bus.result); // RL11
	end

endmodule

// ==== exec_seq.sv ====
// Cycle sequencer: holds off issue for the extra cycles of multi-cycle operations
`timescale 1ns/1ns
`include "core_exec_params.svh"
module exec_seq
	import core_exec_pkg::*;
(
	input  wire logic  mclk,
	input  wire logic  rst_n,
	exec_if.seq        bus
);

	seq_state_t    state_r;   // Current state
	seq_state_t    state_nxt; // Next state
	logic [1:0]    cnt_r;     // Remaining hold cycles
	logic [1:0]    cnt_nxt;   // Next hold count

	// Next-state logic
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		unique case (state_r)
			ST_RUN: begin
				// Multi-cycle operation blocks the next issue
				if (bus.start && (bus.extra != `EXTRA_NONE)) begin
					state_nxt = ST_HOLD;
					cnt_nxt   = bus.extra - 2'h1;
				end
			end
			ST_HOLD: begin
				// Count down the extra cycles
				if (cnt_r == 2'h0) begin
					state_nxt = ST_RUN;
				end else begin
					cnt_nxt = cnt_r - 2'h1;
				end
			end
			default: begin
				state_nxt = ST_RUN;
				cnt_nxt   = 2'h0;
			end
		endcase
	end

	// State registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r <= ST_RUN;
			cnt_r   <= 2'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// Ready is the RUN bit of the one-hot state flop
	assign bus.ready = state_r[0];

endmodule

// ==== core_exec_monitor.sv ====
// Concurrent checks on the ports of the execution subset
`timescale 1ns/1ns
`include "core_exec_params.svh"
module core_exec_monitor (
	input wire logic                mclk,
	input wire logic                rst_n,
	input wire logic                instr_valid,
	input wire logic [2:0]          instr_op,
	input wire logic [`RADDR_W-1:0] instr_reg_addr,
	input wire logic                instr_dest,
	input wire logic [`DATA_W-1:0]  instr_imm,
	input wire logic [`DATA_W-1:0]  reg_rdata,
	input wire logic [`PC_HI_W-1:0] table_high_pointer,
	input wire logic [`PC_W-1:0]    pc_current,
	input wire logic                instr_ready,
	input wire logic [`DATA_W-1:0]  working_register,
	input wire logic                global_interrupt_enable,
	input wire logic                result_null_flag,
	input wire logic                reg_we,
	input wire logic [`RADDR_W-1:0] reg_waddr,
	input wire logic [`DATA_W-1:0]  reg_wdata,
	input wire logic                pc_load,
	input wire logic [`PC_W-1:0]    pc_value,
	input wire logic                stack_push,
	input wire logic [`PC_W-1:0]    stack_data,
	input wire logic                discard_next
);
	// Instruction taken at this edge
	logic take;
	assign take = instr_valid && instr_ready;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_int_enable_set: assert property (take && instr_op == 3'h1 |=> global_interrupt_enable)
		else $error("global enable not set");
	a_inc_work: assert property (take && instr_op == 3'h2 && !instr_dest |=>
		working_register == $past(reg_rdata) + 8'h01 && !reg_we) else $error("increment to working wrong");
	a_inc_reg: assert property (take && instr_op[2:1] == 2'b01 && instr_dest |=> reg_we &&
		reg_waddr == $past(instr_reg_addr) && reg_wdata == $past(reg_rdata) + 8'h01)
		else $error("increment write-back wrong");
	a_skip_hold: assert property (take && instr_op == 3'h3 && reg_rdata == 8'hff |=>
		discard_next && !instr_ready ##1 instr_ready && !discard_next) else $error("skip timing wrong");
	a_skip_none: assert property (take && instr_op == 3'h3 && reg_rdata != 8'hff |=>
		!discard_next && instr_ready) else $error("skip without zero");
	a_jump_target: assert property (take && instr_op == 3'h4 |=> pc_load && !instr_ready &&
		pc_value == {$past(table_high_pointer), $past(working_register)} ##1 !pc_load && instr_ready)
		else $error("jump target or timing wrong");
	a_jump_flags: assert property (take && instr_op == 3'h4 |=> $stable(result_null_flag))
		else $error("jump changed flag");
	a_trap_push: assert property (take && instr_op == 3'h5 |=> stack_push && pc_load &&
		stack_data == $past(pc_current) + 11'h001 && pc_value == 11'h001) else $error("trap wrong");
	a_or_imm: assert property (take && instr_op == 3'h6 |=>
		working_register == ($past(working_register) | $past(instr_imm)) &&
		result_null_flag == (working_register == 8'h00)) else $error("or immediate wrong");
	a_inc_null: assert property (take && instr_op == 3'h2 |=>
		result_null_flag == ($past(reg_rdata) == 8'hff)) else $error("increment flag wrong");
endmodule

bind core_exec core_exec_monitor mon (.mclk, .rst_n, .instr_valid, .instr_op, .instr_reg_addr, .instr_dest,
	.instr_imm, .reg_rdata, .table_high_pointer, .pc_current, .instr_ready, .working_register,
	.global_interrupt_enable, .result_null_flag, .reg_we, .reg_waddr, .reg_wdata, .pc_load, .pc_value,
	.stack_push, .stack_data, .discard_next);

// ==== tb_cpu_instr_exec_subset.sv ====
// Self-checking testbench for the execution subset
`timescale 1ns/1ns
module tb_cpu_instr_exec_subset;
	logic        mclk = 1'b0;              // 250 MHz clock
	logic        rst_n = 1'b0;             // Synchronous reset
	logic        instr_valid = 1'b0;       // Instruction offered
	logic [2:0]  instr_op = 3'h0;          // Operation code
	logic [6:0]  instr_reg_addr = 7'h7f;   // Highest register address
	logic        instr_dest = 1'b0;        // Destination select
	logic [7:0]  instr_imm = 8'h00;        // Immediate field
	logic [7:0]  reg_rdata = 8'h00;        // Register operand value
	logic [2:0]  table_high_pointer = 3'h2; // Jump page
	logic [10:0] pc_current = 11'h7ff;     // Last address, return wraps
	logic        instr_ready, global_interrupt_enable, result_null_flag;
	logic        reg_we, pc_load, stack_push, discard_next;
	logic [7:0]  working_register, reg_wdata;
	logic [6:0]  reg_waddr;
	logic [10:0] pc_value, stack_data;
	int          failures = 0;             // Mismatch count
	int          total_checks = 0;         // Comparison count

	core_exec dut (.mclk, .rst_n, .instr_valid, .instr_op, .instr_reg_addr, .instr_dest, .instr_imm,
		.reg_rdata, .table_high_pointer, .pc_current, .instr_ready, .working_register,
		.global_interrupt_enable, .result_null_flag, .reg_we, .reg_waddr, .reg_wdata, .pc_load,
		.pc_value, .stack_push, .stack_data, .discard_next);

	// Clock
	always #2 mclk = ~mclk;

	// Prints the verdict and ends the run
	task automatic report_and_stop;
		if (failures == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Counts one comparison, reports a miss
	task automatic chk(input int id, input logic ok);
		total_checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("MISMATCH at %0t: check %0d", $time, id);
		end
	endtask

	// Offers one instruction for exactly one accepting edge, returns just after it
	task automatic issue(input logic [2:0] op, input logic [7:0] rd, input logic d, input logic [7:0] im);
		int n;
		n = 0;
		while (instr_ready !== 1'b1) begin
			n++;
			if (n > 20) begin
				failures++;
				$display("MISMATCH at %0t: ready timeout", $time);
				report_and_stop();
			end
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_op <= op;
		reg_rdata <= rd;
		instr_dest <= d;
		instr_imm <= im;
		@(posedge mclk);
		instr_valid <= 1'b0;
		#1;
	endtask

	// One idle cycle, then settle
	task automatic step;
		@(posedge mclk);
		#1;
	endtask

	// Global enable goes high
	task automatic s_enable_int;
		chk(1, global_interrupt_enable === 1'b0);
		issue(3'h1, 8'h00, 1'b0, 8'h00);
		chk(2, global_interrupt_enable === 1'b1);
	endtask

	// Increment with wrap to register 127, then to working
	task automatic s_plus_one;
		issue(3'h2, 8'hff, 1'b1, 8'h00);
		chk(3, reg_we === 1'b1 && reg_waddr === 7'h7f && reg_wdata === 8'h00);
		chk(4, result_null_flag === 1'b1 && working_register === 8'h00);
		step();
		chk(5, reg_we === 1'b0);
		issue(3'h2, 8'h41, 1'b0, 8'h00);
		chk(6, working_register === 8'h42 && result_null_flag === 1'b0 && reg_we === 1'b0);
	endtask

	// Skip on zero holds one cycle, nonzero does not
	task automatic s_skip;
		issue(3'h3, 8'hff, 1'b1, 8'h00);
		chk(7, discard_next === 1'b1 && instr_ready === 1'b0);
		chk(8, reg_we === 1'b1 && reg_wdata === 8'h00 && working_register === 8'h42);
		step();
		chk(9, discard_next === 1'b0 && instr_ready === 1'b1);
		issue(3'h3, 8'h10, 1'b0, 8'h00);
		chk(10, working_register === 8'h11 && discard_next === 1'b0 && instr_ready === 1'b1);
	endtask

	// OR immediate and its zero flag
	task automatic s_or_imm;
		issue(3'h3, 8'hff, 1'b0, 8'h00);
		chk(21, working_register === 8'h00 && result_null_flag === 1'b0 && reg_we === 1'b0);
		issue(3'h6, 8'h00, 1'b0, 8'h00);
		chk(11, working_register === 8'h00 && result_null_flag === 1'b1);
		issue(3'h6, 8'h00, 1'b0, 8'h50);
		chk(12, working_register === 8'h50 && result_null_flag === 1'b0);
		issue(3'h6, 8'h00, 1'b0, 8'haa);
		chk(13, working_register === 8'hfa);
	endtask

	// Computed jump target and one-cycle hold
	task automatic s_jump;
		issue(3'h4, 8'h00, 1'b0, 8'h00);
		chk(14, pc_load === 1'b1 && pc_value === 11'h2fa && instr_ready === 1'b0);
		chk(15, result_null_flag === 1'b0 && working_register === 8'hfa);
		step();
		chk(16, pc_load === 1'b0 && instr_ready === 1'b1);
	endtask

	// Trap pushes wrapped return address and loads the vector
	task automatic s_trap;
		issue(3'h5, 8'h00, 1'b0, 8'h00);
		chk(17, stack_push === 1'b1 && stack_data === 11'h000);
		chk(18, pc_load === 1'b1 && pc_value === 11'h001);
		step();
		chk(19, stack_push === 1'b0 && pc_load === 1'b0 && instr_ready === 1'b1);
		issue(3'h7, 8'hff, 1'b1, 8'hff);
		chk(20, reg_we === 1'b0 && pc_load === 1'b0 && discard_next === 1'b0 && working_register === 8'hfa);
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		step();
		chk(0, instr_ready === 1'b1 && working_register === 8'h00 && pc_load === 1'b0);
		s_enable_int();
		s_plus_one();
		s_skip();
		s_or_imm();
		s_jump();
		s_trap();
		report_and_stop();
	end
endmodule
